// ---- core/lfg_flow_unit.sv ----
// lfg_flow_unit: section gates, skips and edge pulses for a ladder program processor.
// assumes the fetcher presents instructions in program order and honours pcLoad
// by resolving the numbered target itself; scanStart pulses once per scan.
// Operation
// [RULE1] gate opened with OFF condition forces OFF conditions through the next close
// [RULE2] gate ON: each instruction takes its own line condition ANDed with gate
// [RULE3] after a close, normal execution resumes on the following line
// [RULE4] gate open and close carry no operand; close ignores its line condition
// [RULE5] nested gate opens: an OFF inner gate forces OFF up to the close
// [RULE6] skip begin with ON condition behaves as if absent
// [RULE7] skip begin OFF: nothing executed, no operand changed up to target
// [RULE8] skip numbers 00 to 99; 01-99 transfer directly to matching target
// [RULE9] skip instructions carry only the number; target line has no conditions
// [RULE10] skip 00 may repeat; OFF resumes after the next target 00
// [RULE11] skip 00 searches forward instruction by instruction, taking longer
// [RULE12] rising pulse sets bit ON one scan after OFF to ON
// [RULE13] falling pulse holds bit OFF, sets ON one scan after ON to OFF
// [RULE14] next execution of the pulse returns its bit OFF regardless
// [RULE15] pulse is last on its line, operand is one bit address
// [RULE16] each pulse keeps its previous scan condition and compares with current
`timescale 1ns/1ps

module lfg_flow_unit
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scanStart,
  input wire logic instValid,
  output logic instReady,
  input wire logic [lfg_pkg::OPCODE_W-1:0] instOpcode,
  input wire logic [lfg_pkg::OPERAND_W-1:0] instOperand,
  input wire logic [lfg_pkg::SLOT_W-1:0] instSlot,
  input wire logic lineCond,
  output logic execValid,
  output logic execCond,
  output logic bitWrEn,
  output logic [lfg_pkg::OPERAND_W-1:0] bitWrAddr,
  output logic bitWrData,
  output logic pcLoad,
  output logic [lfg_pkg::SKIPNUM_W-1:0] pcLoadNum,
  output logic skipSearch,
  output logic gateOpen,
  output logic badSkipNum
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed
  {
    logic gate;
    logic skipping;
    logic [6:0] skipNum;
    logic execValid;
    logic execCond;
    logic bitWrEn;
    logic [15:0] bitWrAddr;
    logic bitWrData;
    logic pcLoad;
    logic [6:0] pcLoadNum;
    logic badNum;
  } lfg_flow_state_type;

  lfg_flow_state_type cur;
  lfg_flow_state_type next_cur;

  logic gateNow;
  logic skipNow;
  logic [6:0] skipNumNow;
  logic effCond;
  logic live;
  logic [6:0] opNum;
  logic prevCond;
  logic recWr;

  // no buffering: every instruction is decided in the cycle it is offered
  assign instReady = 1'b1;

  assign opNum = instOperand[lfg_pkg::SKIPNUM_LSB +: lfg_pkg::SKIPNUM_W];
  // a scan start in the same cycle as an instruction applies first
  assign gateNow = scanStart ? lfg_pkg::GATE_RESET : cur.gate;
  assign skipNow = scanStart ? lfg_pkg::SKIP_RESET : cur.skipping;
  assign skipNumNow = scanStart ? lfg_pkg::SKIPNUM_RESET : cur.skipNum;
  // [RULE2] gate and line
  assign effCond = lineCond & gateNow;
  assign live = instValid & ~skipNow;

  ////////////////////////////////////////////////////////////////////////////////
  // pulse records

  // [RULE16] previous scan record
  lfg_pulse_record #(
    .SLOTS(lfg_pkg::PULSE_SLOTS)
  ) lfg_pulse_record_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rdSlot(instSlot),
    .rdPrev(prevCond),
    .wrEn(recWr),
    .wrSlot(instSlot),
    .wrCond(effCond)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  always_comb
  begin
    next_cur = cur;
    next_cur.gate = gateNow;
    next_cur.skipping = skipNow;
    next_cur.skipNum = skipNumNow;
    next_cur.execValid = 1'b0;
    next_cur.bitWrEn = 1'b0;
    next_cur.pcLoad = 1'b0;
    recWr = 1'b0;
    if (scanStart)
    begin
      next_cur.badNum = 1'b0;
    end
    if (instValid && skipNow)
    begin
      // [RULE7] skipped body untouched
      // [RULE10] matching target ends it
      if (instOpcode == lfg_pkg::OP_SKIP_TARGET && opNum == skipNumNow)
      begin
        next_cur.skipping = 1'b0;
      end
    end
    else if (instValid)
    begin
      case (instOpcode)
        lfg_pkg::OP_SECTION_GATE_OPEN:
        begin
          // [RULE5] nested gate narrows
          next_cur.gate = effCond;
        end
        lfg_pkg::OP_SECTION_GATE_CLOSE:
        begin
          // [RULE3] resume after close
          // [RULE4] line condition ignored
          next_cur.gate = lfg_pkg::GATE_RESET;
        end
        lfg_pkg::OP_SKIP_BEGIN:
        begin
          // [RULE8] number range check
          if (opNum > lfg_pkg::SKIPNUM_MAX)
          begin
            next_cur.badNum = 1'b1;
          end
          // [RULE6] ON leaves flow alone
          else if (!effCond)
          begin
            next_cur.skipping = 1'b1;
            next_cur.skipNum = opNum;
            // [RULE11] 00 searches, others transfer
            if (opNum != lfg_pkg::SKIPNUM_SEARCH)
            begin
              next_cur.pcLoad = 1'b1;
              next_cur.pcLoadNum = opNum;
            end
          end
        end
        lfg_pkg::OP_SKIP_TARGET:
        begin
          // [RULE9] a target reached normally does nothing
          next_cur.skipping = 1'b0;
        end
        lfg_pkg::OP_RISING_PULSE_OUT,
        lfg_pkg::OP_FALLING_PULSE_OUT:
        begin
          // [RULE15] single bit write
          recWr = 1'b1;
          next_cur.bitWrEn = 1'b1;
          next_cur.bitWrAddr = instOperand;
          // [RULE14] no edge gives OFF
          if (instOpcode == lfg_pkg::OP_RISING_PULSE_OUT)
          begin
            // [RULE12] OFF to ON
            next_cur.bitWrData = effCond & ~prevCond;
          end
          else
          begin
            // [RULE13] ON to OFF
            next_cur.bitWrData = ~effCond & prevCond;
          end
        end
        default:
        begin
          // [RULE1] gated-off sections see OFF
          next_cur.execValid = 1'b1;
          next_cur.execCond = effCond;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur.gate <= lfg_pkg::GATE_RESET;
      cur.skipping <= lfg_pkg::SKIP_RESET;
      cur.skipNum <= lfg_pkg::SKIPNUM_RESET;
      cur.execValid <= 1'b0;
      cur.execCond <= 1'b0;
      cur.bitWrEn <= 1'b0;
      cur.bitWrAddr <= lfg_pkg::ADDR_RESET;
      cur.bitWrData <= 1'b0;
      cur.pcLoad <= 1'b0;
      cur.pcLoadNum <= lfg_pkg::SKIPNUM_RESET;
      cur.badNum <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign execValid = cur.execValid;
  assign execCond = cur.execCond;
  assign bitWrEn = cur.bitWrEn;
  assign bitWrAddr = cur.bitWrAddr;
  assign bitWrData = cur.bitWrData;
  assign pcLoad = cur.pcLoad;
  assign pcLoadNum = cur.pcLoadNum;
  assign skipSearch = cur.skipping;
  assign gateOpen = cur.gate;
  assign badSkipNum = cur.badNum;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic isOp;
  logic isPulse;
  assign isOp = live && instOpcode != lfg_pkg::OP_SECTION_GATE_OPEN
    && instOpcode != lfg_pkg::OP_SECTION_GATE_CLOSE
    && instOpcode != lfg_pkg::OP_SKIP_BEGIN
    && instOpcode != lfg_pkg::OP_SKIP_TARGET
    && instOpcode != lfg_pkg::OP_RISING_PULSE_OUT
    && instOpcode != lfg_pkg::OP_FALLING_PULSE_OUT;
  assign isPulse = live && (instOpcode == lfg_pkg::OP_RISING_PULSE_OUT
    || instOpcode == lfg_pkg::OP_FALLING_PULSE_OUT);

  gate_forces_off_a: assert property (isOp && !gateNow |=> execValid && !execCond) // [RULE1]
    else $error("gated-off instruction did not see OFF");
  gate_and_cond_a: assert property (isOp && gateNow |=> execCond == $past(lineCond)) // [RULE2]
    else $error("gated instruction condition differs from line");
  gate_close_a: assert property ( // [RULE3]
    live && instOpcode == lfg_pkg::OP_SECTION_GATE_CLOSE ##1 isOp |=> execCond == $past(lineCond))
    else $error("close did not restore normal conditions");
  gate_nested_a: assert property ( // [RULE5]
    live && instOpcode == lfg_pkg::OP_SECTION_GATE_OPEN && !effCond |=> !gateOpen)
    else $error("inner gate OFF did not close section");
  skip_pass_a: assert property ( // [RULE6]
    live && instOpcode == lfg_pkg::OP_SKIP_BEGIN && effCond |=> !skipSearch && !pcLoad)
    else $error("ON skip changed flow");
  skip_hold_a: assert property (skipSearch && !scanStart |=> !execValid && !bitWrEn) // [RULE7]
    else $error("instruction executed inside a skip");
  skip_direct_a: assert property ( // [RULE8]
    live && instOpcode == lfg_pkg::OP_SKIP_BEGIN && !effCond && opNum != 7'h00
    && opNum <= lfg_pkg::SKIPNUM_MAX |=> pcLoad && pcLoadNum == $past(opNum) ##1 !pcLoad)
    else $error("numbered skip did not request a one-cycle transfer");
  skip_search_a: assert property ( // [RULE11]
    live && instOpcode == lfg_pkg::OP_SKIP_BEGIN && !effCond && opNum == 7'h00
    |=> skipSearch && !pcLoad)
    else $error("skip 00 did not start a search");
  rise_pulse_a: assert property ( // [RULE12]
    live && instOpcode == lfg_pkg::OP_RISING_PULSE_OUT
    |=> bitWrEn && bitWrData == ($past(effCond) && !$past(prevCond)))
    else $error("rising pulse value wrong");
  fall_pulse_a: assert property ( // [RULE13]
    live && instOpcode == lfg_pkg::OP_FALLING_PULSE_OUT
    |=> bitWrEn && bitWrData == (!$past(effCond) && $past(prevCond)))
    else $error("falling pulse value wrong");
  pulse_addr_a: assert property (isPulse |=> bitWrAddr == $past(instOperand)) // [RULE15]
    else $error("pulse wrote wrong bit address");

  gate_off_c: cover property (isOp && !gateNow);
  skip_direct_c: cover property (pcLoad ##[1:20] !skipSearch);
  skip_search_c: cover property (skipSearch [*3] ##1 !skipSearch);
  rise_pulse_c: cover property (bitWrEn && bitWrData);

endmodule

// ---- pkg/lfg_pkg.sv ----
// lfg_pkg: opcodes, field layout and reset values for the ladder flow gate and edge unit.
// assumes the fetch side delivers one decoded instruction word per accepted cycle.
package lfg_pkg;

  localparam int OPCODE_W = 8;
  localparam int OPERAND_W = 16;
  localparam int SKIPNUM_W = 7;
  localparam int SLOT_W = 6;
  localparam int PULSE_SLOTS = 64;

  // instruction codes carried on the fetch port
  localparam logic [7:0] OP_SECTION_GATE_OPEN = 8'h02;
  localparam logic [7:0] OP_SECTION_GATE_CLOSE = 8'h03;
  localparam logic [7:0] OP_SKIP_BEGIN = 8'h04;
  localparam logic [7:0] OP_SKIP_TARGET = 8'h05;
  localparam logic [7:0] OP_RISING_PULSE_OUT = 8'h13;
  localparam logic [7:0] OP_FALLING_PULSE_OUT = 8'h14;

  // skip number field position and legal range
  localparam int SKIPNUM_LSB = 0;
  localparam logic [6:0] SKIPNUM_SEARCH = 7'h00;
  localparam logic [6:0] SKIPNUM_MAX = 7'h63;

  // values after reset; gate, skip and skip number values also at every scan start
  localparam logic GATE_RESET = 1'b1;
  localparam logic SKIP_RESET = 1'b0;
  localparam logic [6:0] SKIPNUM_RESET = 7'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [63:0] RECORD_RESET = 64'h0000_0000_0000_0000;

endpackage

// ---- core/lfg_pulse_record.sv ----
// lfg_pulse_record: one bit per pulse instruction holding its condition from the previous scan.
// assumes one read and at most one write per cycle, both on the same slot index.
`timescale 1ns/1ps

module lfg_pulse_record
#(
  parameter int SLOTS = 64
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [lfg_pkg::SLOT_W-1:0] rdSlot,
  output logic rdPrev,
  input wire logic wrEn,
  input wire logic [lfg_pkg::SLOT_W-1:0] wrSlot,
  input wire logic wrCond
);

  typedef struct packed
  {
    logic [SLOTS-1:0] prev;
  } lfg_rec_state_type;

  lfg_rec_state_type cur;
  lfg_rec_state_type next_cur;

  assign rdPrev = cur.prev[rdSlot];

  always_comb
  begin
    next_cur = cur;
    if (wrEn)
    begin
      next_cur.prev[wrSlot] = wrCond;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= lfg_rec_state_type'(lfg_pkg::RECORD_RESET);
    end
    else
    begin
      cur <= next_cur;
    end
  end

endmodule

// ---- tb/ladder_flow_gate_and_edge_unit_tb.sv ----
// flow unit bench: section gates, skips and edge pulses as directed scenarios.
// assumes the flow unit alone; inputs change on the falling edge, results read at the next falling edge.
`timescale 1ns/1ps

module ladder_flow_gate_and_edge_unit_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scanStart = 1'b0;
  logic instValid = 1'b0;
  logic [lfg_pkg::OPCODE_W-1:0] instOpcode = 8'h00;
  logic [lfg_pkg::OPERAND_W-1:0] instOperand = 16'h0000;
  logic [lfg_pkg::SLOT_W-1:0] instSlot = 6'h00;
  logic lineCond = 1'b0;
  logic instReady;
  logic execValid;
  logic execCond;
  logic bitWrEn;
  logic [lfg_pkg::OPERAND_W-1:0] bitWrAddr;
  logic bitWrData;
  logic pcLoad;
  logic [lfg_pkg::SKIPNUM_W-1:0] pcLoadNum;
  logic skipSearch;
  logic gateOpen;
  logic badSkipNum;
  int badCount = 0;
  int checksDone = 0;
  int cycles = 0;

  always #2 ref_clk = ~ref_clk;

  lfg_flow_unit lfg_flow_unit_inst
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scanStart(scanStart),
    .instValid(instValid),
    .instReady(instReady),
    .instOpcode(instOpcode),
    .instOperand(instOperand),
    .instSlot(instSlot),
    .lineCond(lineCond),
    .execValid(execValid),
    .execCond(execCond),
    .bitWrEn(bitWrEn),
    .bitWrAddr(bitWrAddr),
    .bitWrData(bitWrData),
    .pcLoad(pcLoad),
    .pcLoadNum(pcLoadNum),
    .skipSearch(skipSearch),
    .gateOpen(gateOpen),
    .badSkipNum(badSkipNum)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // the whole run is far below this; a stuck design ends the run here
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      badCount++;
      reportAndStop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one instruction per call; outputs describe it when the call returns
  task automatic send(input logic [7:0] op, input logic [15:0] opr, input logic [5:0] s,
                      input logic c);
    instValid = 1'b1;
    instOpcode = op;
    instOperand = opr;
    instSlot = s;
    lineCond = c;
    @(negedge ref_clk);
  endtask

  task automatic newScan();
    instValid = 1'b0;
    scanStart = 1'b1;
    @(negedge ref_clk);
    scanStart = 1'b0;
  endtask

  task automatic ord(input logic c);
    send(8'haa, 16'h0000, 6'h00, c);
  endtask

  task automatic gate(input logic c);
    send(lfg_pkg::OP_SECTION_GATE_OPEN, 16'h0000, 6'h00, c);
  endtask

  task automatic gateEnd(input logic c);
    send(lfg_pkg::OP_SECTION_GATE_CLOSE, 16'h0000, 6'h00, c);
  endtask

  task automatic skip(input logic [6:0] n, input logic c);
    send(lfg_pkg::OP_SKIP_BEGIN, {9'h000, n}, 6'h00, c);
  endtask

  task automatic tgt(input logic [6:0] n);
    send(lfg_pkg::OP_SKIP_TARGET, {9'h000, n}, 6'h00, 1'b0);
  endtask

  task automatic pulse(input logic fall, input logic [5:0] s, input logic c, input logic d);
    send(fall ? lfg_pkg::OP_FALLING_PULSE_OUT : lfg_pkg::OP_RISING_PULSE_OUT,
         {10'h008, s}, s, c);
    check(16'(bitWrEn), 16'h1);
    check(bitWrAddr, {10'h008, s});
    check(16'(bitWrData), 16'(d));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic tGate();
    newScan();
    check(16'(gateOpen), 16'h1);
    pulse(1'b1, 6'h05, 1'b1, 1'b0);
    gate(1'b0);
    check(16'(gateOpen), 16'h0);
    ord(1'b1);
    check(16'(execValid), 16'h1);
    check(16'(execCond), 16'h0);
    // the forced OFF condition is itself a falling edge for the pulse
    pulse(1'b1, 6'h05, 1'b1, 1'b1);
    gateEnd(1'b0);
    check(16'(gateOpen), 16'h1);
    ord(1'b1);
    check(16'(execCond), 16'h1);
    gate(1'b1);
    ord(1'b0);
    check(16'(execCond), 16'h0);
    ord(1'b1);
    check(16'(execCond), 16'h1);
    gateEnd(1'b1);
  endtask

  task automatic tNested();
    newScan();
    gate(1'b1);
    gate(1'b0);
    check(16'(gateOpen), 16'h0);
    ord(1'b1);
    check(16'(execCond), 16'h0);
    gate(1'b1);
    check(16'(gateOpen), 16'h0);
    gateEnd(1'b1);
    check(16'(gateOpen), 16'h1);
  endtask

  task automatic tSkipNum();
    newScan();
    skip(7'h01, 1'b0);
    check(16'(pcLoad), 16'h1);
    check(16'(pcLoadNum), 16'h0001);
    check(16'(skipSearch), 16'h1);
    ord(1'b1);
    check(16'(execValid), 16'h0);
    send(lfg_pkg::OP_RISING_PULSE_OUT, 16'h0206, 6'h06, 1'b1);
    check(16'(bitWrEn), 16'h0);
    gate(1'b0);
    check(16'(gateOpen), 16'h1);
    tgt(7'h02);
    check(16'(skipSearch), 16'h1);
    tgt(7'h01);
    check(16'(skipSearch), 16'h0);
    ord(1'b1);
    check(16'(execCond), 16'h1);
    // the skipped pulse must not have touched its record
    pulse(1'b0, 6'h06, 1'b1, 1'b1);
    skip(7'h63, 1'b0);
    check(16'(pcLoadNum), 16'h0063);
    tgt(7'h63);
    skip(7'h64, 1'b0);
    check(16'(badSkipNum), 16'h1);
    check(16'(skipSearch), 16'h0);
    newScan();
    check(16'(badSkipNum), 16'h0);
  endtask

  task automatic tSkipOn();
    skip(7'h05, 1'b1);
    check(16'(pcLoad), 16'h0);
    check(16'(skipSearch), 16'h0);
    ord(1'b0);
    check(16'(execValid), 16'h1);
  endtask

  task automatic tSkipZero();
    newScan();
    skip(7'h00, 1'b0);
    check(16'(pcLoad), 16'h0);
    check(16'(skipSearch), 16'h1);
    skip(7'h00, 1'b0);
    tgt(7'h01);
    check(16'(skipSearch), 16'h1);
    tgt(7'h00);
    check(16'(skipSearch), 16'h0);
    ord(1'b1);
    check(16'(execValid), 16'h1);
    skip(7'h00, 1'b0);
    check(16'(skipSearch), 16'h1);
    // a new scan abandons an unfinished search; its first instruction runs
    scanStart = 1'b1;
    ord(1'b1);
    scanStart = 1'b0;
    check(16'(execValid), 16'h1);
    check(16'(skipSearch), 16'h0);
  endtask

  task automatic tPulse();
    pulse(1'b0, 6'h03, 1'b0, 1'b0);
    pulse(1'b0, 6'h03, 1'b1, 1'b1);
    pulse(1'b0, 6'h3f, 1'b0, 1'b0);
    pulse(1'b0, 6'h03, 1'b1, 1'b0);
    pulse(1'b1, 6'h04, 1'b1, 1'b0);
    pulse(1'b1, 6'h04, 1'b1, 1'b0);
    pulse(1'b1, 6'h04, 1'b0, 1'b1);
    pulse(1'b1, 6'h04, 1'b0, 1'b0);
  endtask

  // a mid-run reset clears the records, so a held ON level is an edge again
  task automatic tReset();
    pulse(1'b0, 6'h07, 1'b1, 1'b1);
    instValid = 1'b0;
    rst_n = 1'b0;
    @(negedge ref_clk);
    check(16'(gateOpen), 16'h1);
    check(16'(skipSearch), 16'h0);
    check(16'(bitWrEn), 16'h0);
    check(16'(instReady), 16'h1);
    rst_n = 1'b1;
    @(negedge ref_clk);
    pulse(1'b0, 6'h07, 1'b1, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    tGate();
    tNested();
    tSkipNum();
    tSkipOn();
    tSkipZero();
    tPulse();
    tReset();
    reportAndStop();
  end
endmodule
